//--- pkg/actuator_cfg_pkg.sv
package actuator_cfg_pkg;

   // register addresses
   localparam logic [7:0] ADDR_DRIVE_MODE_SELECT = 8'h06;
   localparam logic [7:0] ADDR_RESONANCE_TUNING  = 8'h07;

   // drive_mode_select field layout
   localparam int RING_MODE_BIT   = 0;
   localparam int OUTPUT_MODE_BIT = 1;
   localparam int RATE_LSB        = 2;
   localparam int RATE_MSB        = 4;

   localparam logic [7:0] MODE_WRITABLE_MASK = 8'h1F;
   localparam logic [7:0] MODE_RESET         = 8'h00;
   localparam logic [7:0] RESONANCE_RESET    = 8'h83;

   // resonance code conversion figures
   localparam int RES_OFFSET  = 383;
   localparam int RES_NUMER   = 19200;

   // switching rate codes
   typedef enum logic [2:0] {
      RATE_0M5 = 3'h0,
      RATE_1M  = 3'h1,
      RATE_NA2 = 3'h2,
      RATE_2M  = 3'h3,
      RATE_NA4 = 3'h4,
      RATE_4M8 = 3'h5,
      RATE_6M  = 3'h6,
      RATE_4M  = 3'h7
   } switch_rate_type;

   // switching rate in kHz, driven out for the output stage
   localparam logic [12:0] KHZ_0M5 = 13'h01F4;
   localparam logic [12:0] KHZ_1M  = 13'h03E8;
   localparam logic [12:0] KHZ_2M  = 13'h07D0;
   localparam logic [12:0] KHZ_4M8 = 13'h12C0;
   localparam logic [12:0] KHZ_6M  = 13'h1770;
   localparam logic [12:0] KHZ_4M  = 13'h0FA0;
   localparam logic [12:0] KHZ_NONE = 13'h0000;

   localparam logic [1:0] SETTLE_TWO_PERIODS = 2'h2;
   localparam logic [1:0] SETTLE_ONE_PERIOD  = 2'h1;

endpackage

//--- rtl/lens_actuator_mode_config.sv
`timescale 1ns/1ps
module lens_actuator_mode_config
   import actuator_cfg_pkg::*;
(
   // clock and reset
   input  wire logic        CORE_CLK_IN,
   input  wire logic        RESET_IN,
   input  wire logic        CLK_EN_IN,
   // register port from the serial slave
   input  wire logic [7:0]  REG_ADDR_IN,
   input  wire logic [7:0]  REG_WDATA_IN,
   input  wire logic        REG_WRITE_IN,
   input  wire logic        REG_READ_IN,
   output logic      [7:0]  REG_RDATA_OUT,
   output logic             REG_RVALID_OUT,
   // configuration towards the output stage
   output logic      [1:0]  SETTLE_PERIODS_OUT,
   output logic             LINEAR_MODE_OUT,
   output logic      [2:0]  SWITCH_RATE_SELECT_OUT,
   output logic      [12:0] SWITCH_RATE_KHZ_OUT,
   output logic             RATE_CODE_INVALID_OUT,
   output logic      [7:0]  RESONANCE_CODE_OUT
);
   import actuator_cfg_pkg::*;

   logic [7:0]      mode_r;
   logic [7:0]      mode_nxt;
   logic [7:0]      res_r;
   logic [7:0]      rdata_nxt;
   logic [12:0]     khz_nxt;
   logic            bad_nxt;
   switch_rate_type rate;

   assign mode_nxt = REG_WDATA_IN & MODE_WRITABLE_MASK;
   assign rate     = switch_rate_type'(mode_r[RATE_MSB:RATE_LSB]);

   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         mode_r <= MODE_RESET;
      end else if (CLK_EN_IN && REG_WRITE_IN && REG_ADDR_IN == ADDR_DRIVE_MODE_SELECT) begin
         mode_r <= mode_nxt;
      end
   end

   // resonance code is stored as written; the host owns the conversion
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         res_r <= RESONANCE_RESET;
      end else if (CLK_EN_IN && REG_WRITE_IN && REG_ADDR_IN == ADDR_RESONANCE_TUNING) begin
         res_r <= REG_WDATA_IN;
      end
   end

   always_comb begin
      if (REG_ADDR_IN == ADDR_DRIVE_MODE_SELECT) begin
         rdata_nxt = mode_r;
      end else if (REG_ADDR_IN == ADDR_RESONANCE_TUNING) begin
         rdata_nxt = res_r;
      end else begin
         rdata_nxt = 8'h00;
      end
   end

   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         REG_RDATA_OUT  <= 8'h00;
         REG_RVALID_OUT <= 1'b0;
      end else if (CLK_EN_IN) begin
         REG_RVALID_OUT <= REG_READ_IN;
         if (REG_READ_IN) begin
            REG_RDATA_OUT <= rdata_nxt;
         end
      end
   end

   // unavailable codes still store; they are flagged and give no rate
   always_comb begin
      bad_nxt = 1'b0;
      case (rate)
         RATE_0M5: khz_nxt = KHZ_0M5;
         RATE_1M:  khz_nxt = KHZ_1M;
         RATE_2M:  khz_nxt = KHZ_2M;
         RATE_4M8: khz_nxt = KHZ_4M8;
         RATE_6M:  khz_nxt = KHZ_6M;
         RATE_4M:  khz_nxt = KHZ_4M;
         default: begin
            khz_nxt = KHZ_NONE;
            bad_nxt = 1'b1;
         end
      endcase
   end

   // outputs follow the registers one cycle later
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         SETTLE_PERIODS_OUT     <= SETTLE_TWO_PERIODS;
         LINEAR_MODE_OUT        <= 1'b0;
         SWITCH_RATE_SELECT_OUT <= 3'h0;
         SWITCH_RATE_KHZ_OUT    <= KHZ_0M5;
         RATE_CODE_INVALID_OUT  <= 1'b0;
         RESONANCE_CODE_OUT     <= RESONANCE_RESET;
      end else if (CLK_EN_IN) begin
         SETTLE_PERIODS_OUT     <= mode_r[RING_MODE_BIT] ? SETTLE_ONE_PERIOD : SETTLE_TWO_PERIODS;
         LINEAR_MODE_OUT        <= mode_r[OUTPUT_MODE_BIT];
         SWITCH_RATE_SELECT_OUT <= mode_r[RATE_MSB:RATE_LSB];
         SWITCH_RATE_KHZ_OUT    <= khz_nxt;
         RATE_CODE_INVALID_OUT  <= bad_nxt;
         RESONANCE_CODE_OUT     <= res_r;
      end
   end

   a_mode_upper_zero: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      mode_r[7:5] == 3'h0) else $error("mode upper bits not zero");

   // strobes as the register port takes them; each takes effect one edge later
   sequence s_mode_write;
      CLK_EN_IN && REG_WRITE_IN && REG_ADDR_IN == ADDR_DRIVE_MODE_SELECT;
   endsequence

   sequence s_res_write;
      CLK_EN_IN && REG_WRITE_IN && REG_ADDR_IN == ADDR_RESONANCE_TUNING;
   endsequence

   sequence s_mode_read;
      CLK_EN_IN && REG_READ_IN && REG_ADDR_IN == ADDR_DRIVE_MODE_SELECT;
   endsequence

   sequence s_res_read;
      CLK_EN_IN && REG_READ_IN && REG_ADDR_IN == ADDR_RESONANCE_TUNING;
   endsequence

   a_mode_write: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      s_mode_write |=> mode_r == ($past(REG_WDATA_IN) & MODE_WRITABLE_MASK))
      else $error("mode write wrong");

   a_mode_hold: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      !(CLK_EN_IN && REG_WRITE_IN && REG_ADDR_IN == ADDR_DRIVE_MODE_SELECT) |=> $stable(mode_r))
      else $error("mode changed without write");

   a_settle_follows: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      CLK_EN_IN |=> SETTLE_PERIODS_OUT == ($past(mode_r[RING_MODE_BIT]) ? SETTLE_ONE_PERIOD : SETTLE_TWO_PERIODS))
      else $error("settle periods wrong");

   a_linear_follows: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      CLK_EN_IN |=> LINEAR_MODE_OUT == $past(mode_r[OUTPUT_MODE_BIT]))
      else $error("output mode wrong");

   a_select_copy: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      CLK_EN_IN |=> SWITCH_RATE_SELECT_OUT == $past(mode_r[RATE_MSB:RATE_LSB]))
      else $error("rate select copy wrong");

   a_rate_0m5: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (CLK_EN_IN && rate == RATE_0M5) |=> SWITCH_RATE_KHZ_OUT == KHZ_0M5)
      else $error("rate 0.5 MHz wrong");

   a_rate_1m: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (CLK_EN_IN && rate == RATE_1M) |=> SWITCH_RATE_KHZ_OUT == KHZ_1M)
      else $error("rate 1 MHz wrong");

   a_rate_2m: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (CLK_EN_IN && rate == RATE_2M) |=> SWITCH_RATE_KHZ_OUT == KHZ_2M)
      else $error("rate 2 MHz wrong");

   a_rate_4m8: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (CLK_EN_IN && rate == RATE_4M8) |=> SWITCH_RATE_KHZ_OUT == KHZ_4M8)
      else $error("rate 4.8 MHz wrong");

   a_rate_6m: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (CLK_EN_IN && rate == RATE_6M) |=> SWITCH_RATE_KHZ_OUT == KHZ_6M)
      else $error("rate 6 MHz wrong");

   a_rate_4m: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (CLK_EN_IN && rate == RATE_4M) |=> SWITCH_RATE_KHZ_OUT == KHZ_4M)
      else $error("rate 4 MHz wrong");

   a_rate_valid: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (CLK_EN_IN && rate != RATE_NA2 && rate != RATE_NA4) |=> !RATE_CODE_INVALID_OUT)
      else $error("available rate flagged");

   a_rate_invalid: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (CLK_EN_IN && (rate == RATE_NA2 || rate == RATE_NA4)) |=> RATE_CODE_INVALID_OUT && SWITCH_RATE_KHZ_OUT == KHZ_NONE)
      else $error("unavailable rate not flagged");

   a_res_store: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      s_res_write |=> res_r == $past(REG_WDATA_IN))
      else $error("resonance code not stored");

   a_res_hold: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      !(CLK_EN_IN && REG_WRITE_IN && REG_ADDR_IN == ADDR_RESONANCE_TUNING) |=> $stable(res_r))
      else $error("resonance code changed without write");

   a_res_out: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      CLK_EN_IN |=> RESONANCE_CODE_OUT == $past(res_r))
      else $error("resonance output wrong");

   a_res_reset: assert property (@(posedge CORE_CLK_IN)
      $fell(RESET_IN) |-> res_r == RESONANCE_RESET && RESONANCE_CODE_OUT == RESONANCE_RESET)
      else $error("resonance reset wrong");

   a_read_mode: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      s_mode_read |=> REG_RVALID_OUT && REG_RDATA_OUT == $past(mode_r))
      else $error("mode readback wrong");

   a_read_res: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      s_res_read |=> REG_RVALID_OUT && REG_RDATA_OUT == $past(res_r))
      else $error("resonance readback wrong");

   a_read_unmapped: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (CLK_EN_IN && REG_READ_IN && REG_ADDR_IN != ADDR_DRIVE_MODE_SELECT && REG_ADDR_IN != ADDR_RESONANCE_TUNING)
      |=> REG_RDATA_OUT == 8'h00) else $error("unmapped read not zero");

   a_rvalid_pulse: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (CLK_EN_IN && !REG_READ_IN) |=> !REG_RVALID_OUT && $stable(REG_RDATA_OUT))
      else $error("read valid without read");

   // a frozen enable must leave the settle periods, linear mode and resonance code outputs where they were
   a_freeze_cfg: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      !CLK_EN_IN |=> $stable(SETTLE_PERIODS_OUT) && $stable(LINEAR_MODE_OUT) && $stable(RESONANCE_CODE_OUT))
      else $error("outputs moved while frozen");

endmodule // lens_actuator_mode_config

//--- verification/cfg_host_model.sv
`timescale 1ns/1ps
module cfg_host_model (
   // clock
   input  wire logic       clk_in,
   // register port
   output logic      [7:0] addr_out,
   output logic      [7:0] wdata_out,
   output logic            write_out,
   output logic            read_out
);
   import actuator_cfg_pkg::*;

   initial begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      write_out = 1'b0;
      read_out = 1'b0;
   end
   // host side rounds to nearest; results below 0 or above 255 are the caller's problem
   function automatic logic [7:0] code(input real f);
      return 8'($rtoi(real'(RES_OFFSET) - real'(RES_NUMER) / f + 0.5));
   endfunction
   // one strobe cycle; released data shows the inverse so stale values never match
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      addr_out = a;
      wdata_out = d;
      write_out = w;
      read_out = ~w;
      @(negedge clk_in);
      write_out = 1'b0;
      read_out = 1'b0;
      wdata_out = ~d;
   endtask
endmodule // cfg_host_model

//--- verification/tb_lens_actuator_mode_config.sv
`timescale 1ns/1ps
module tb_lens_actuator_mode_config;
   import actuator_cfg_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cen = 1'b1;
   logic [7:0]  addr, wdata, rdata, res;
   logic        wr, rd, rvalid, lin, inv;
   logic [1:0]  settle;
   logic [2:0]  sel;
   logic [12:0] khz;
   int          err_total = 0;
   int          num_checks = 0;
   // rate code in, kHz out
   logic [12:0] rows [8] = '{KHZ_0M5, KHZ_1M, KHZ_NONE, KHZ_2M, KHZ_NONE, KHZ_4M8, KHZ_6M, KHZ_4M};
   always #20 clk = ~clk;
   cfg_host_model cfg_host_model_inst (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .write_out(wr),
      .read_out(rd));
   lens_actuator_mode_config lens_actuator_mode_config_inst (.CORE_CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(cen),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WRITE_IN(wr), .REG_READ_IN(rd), .REG_RDATA_OUT(rdata),
      .REG_RVALID_OUT(rvalid), .SETTLE_PERIODS_OUT(settle), .LINEAR_MODE_OUT(lin), .SWITCH_RATE_SELECT_OUT(sel),
      .SWITCH_RATE_KHZ_OUT(khz), .RATE_CODE_INVALID_OUT(inv), .RESONANCE_CODE_OUT(res));
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      cfg_host_model_inst.acc(1'b0, a, 8'h00);
      chk({rvalid, rdata}, {1'b1, e});
   endtask
   task automatic results;
      if (err_total == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #20000;
      err_total++;
      results();
   end
   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      chk({settle, lin, inv, khz}, {SETTLE_TWO_PERIODS, 2'b00, KHZ_0M5});
      chk(res, RESONANCE_RESET);
      rdchk(ADDR_RESONANCE_TUNING, RESONANCE_RESET);
      rdchk(ADDR_DRIVE_MODE_SELECT, MODE_RESET);
      // upper bits always written as ones so a leak shows on readback
      for (int i = 0; i < 8; i++) begin
         cfg_host_model_inst.acc(1'b1, ADDR_DRIVE_MODE_SELECT, {3'h7, i[2:0], i[1:0]});
         @(negedge clk);
         chk({settle, lin}, {(i[0] ? SETTLE_ONE_PERIOD : SETTLE_TWO_PERIODS), i[1]});
         chk({sel, inv, khz}, {i[2:0], (i == 2 || i == 4), rows[i]});
         rdchk(ADDR_DRIVE_MODE_SELECT, {3'h0, i[2:0], i[1:0]});
      end
      cfg_host_model_inst.acc(1'b1, ADDR_RESONANCE_TUNING, cfg_host_model_inst.code(100.0));
      @(negedge clk);
      chk(res, 8'hBF);
      rdchk(ADDR_RESONANCE_TUNING, 8'hBF);
      rdchk(8'h08, 8'h00);
      // frozen clock enable must swallow the write
      cen = 1'b0;
      cfg_host_model_inst.acc(1'b1, ADDR_RESONANCE_TUNING, 8'h10);
      cen = 1'b1;
      repeat (2) @(negedge clk);
      chk(res, 8'hBF);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      chk(res, RESONANCE_RESET);
      rdchk(ADDR_DRIVE_MODE_SELECT, MODE_RESET);
      @(negedge clk);
      chk(rvalid, 1'b0);
      results();
   end
endmodule // tb_lens_actuator_mode_config
